// ===== inc/vref_addr_map.vh
`ifndef VREF_ADDR_MAP_VH
`define VREF_ADDR_MAP_VH

// ****************************************************************
// address decode
// ****************************************************************
`define ADDR_UPPER_BITS      4'h4
`define ADDR_GLOBAL          7'h5A
`define RAIL_DIS_BIT         7
`define RAIL_RESET           8'h80

// ****************************************************************
// reference control
// ****************************************************************
`define REF_WIDTH            9
`define REF_RESET            9'h000
`define REF_STEP_PERMIL      2
`define OP_RESET             8'h00
`define OP_ON_BIT            7
`define OP_MARGIN_HI_BIT     5
`define OP_MARGIN_LO_BIT     4
`define OP_VAL_OFF           8'h00
`define OP_VAL_ON            8'h80
`define OP_VAL_MLOW          8'h98
`define OP_VAL_MHIGH         8'hA8
`define CFG_RESET            8'h00
`define SLEW_NOMINAL         2'b00
`define SLEW_SLOW            2'b01
`define SLEW_FAST            2'b10
`define SLEW_ILLEGAL         2'b11

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_PS        25000
// 23 %/ms at 0.2 % per step gives one step each 8696 ns
`define DEFAULT_STEP_NS      8696
// 8696 ns over a 25 ns clock, rounded down to 347 cycles
`define DEFAULT_STEP_CYC     24'h00_015B
`define BYPASS_LIMIT_NS      100
`define PERIOD_WIDTH         24

`endif

// ===== core/step_timer.v
`timescale 1ns/1ps
`include "vref_addr_map.vh"

// counts one step period, scaled by the slew multiplier
module step_timer (
	// clock and reset
	input  wire                       clk,
	input  wire                       arst_n,
	// control
	input  wire                       active,
	input  wire [`PERIOD_WIDTH-1:0]   base_period,
	input  wire [1:0]                 slew_mult,
	// result
	output reg                        tick
);
	reg  [`PERIOD_WIDTH+2:0] cnt_q;
	reg  [`PERIOD_WIDTH+2:0] limit;

	always @* begin
		case (slew_mult)
			`SLEW_SLOW: limit = {base_period, 3'b000};
			`SLEW_FAST: limit = {3'b000, 1'b0, base_period[`PERIOD_WIDTH-1:1]};
			// illegal code falls back to nominal rather than stalling
			default:    limit = {3'b000, base_period};
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= {(`PERIOD_WIDTH+3){1'b0}};
			tick  <= 1'b0;
		end else if (!active) begin
			cnt_q <= {(`PERIOD_WIDTH+3){1'b0}};
			tick  <= 1'b0;
		end else if (cnt_q + 1'b1 >= limit) begin
			cnt_q <= {(`PERIOD_WIDTH+3){1'b0}};
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule // step_timer

// ===== core/vout_reference_and_address.v
`timescale 1ns/1ps
`include "vref_addr_map.vh"

// What this block does
// RULE_01: upper four address bits fixed 0100
// RULE_02: strap gives low three address bits
// RULE_03: also answer global address 0x5A
// RULE_04: also answer shared rail address
// RULE_05: strap sampled at power-on, run, on edges
// RULE_06: nine-bit reference, 0.2 percent per code
// RULE_07: operation bits 5:4 choose reference source
// RULE_08: both margin bits high keeps normal setting
// RULE_09: reference steps toward target one code
// RULE_10: step time scaled by multiplier and capacitor
// RULE_11: open capacitor pin gives 23 percent/ms
// RULE_12: capacitor tied high jumps at once
// RULE_13: operation values off, on, margin low, high
// RULE_14: config bits 1:0 pick slew multiplier
// RULE_15: rail address enabled only while bit7 low
// RULE_16: compare all addresses in parallel
// RULE_17: step counter advances reference to target
module vout_reference_and_address #(
	parameter [`PERIOD_WIDTH-1:0] DEFAULT_STEP_CYCLES = `DEFAULT_STEP_CYC
) (
	// clock and reset
	input  wire                     clk,
	input  wire                     arst_n,
	// pins from outside the clock domain
	input  wire [2:0]               addr_strap_pin,
	input  wire                     run_pin,
	input  wire                     slew_cap_open,
	input  wire                     slew_cap_bypass,
	// capacitor derived step period in clock cycles
	input  wire [`PERIOD_WIDTH-1:0] slew_cap_period,
	// settings written by the bus engine
	input  wire [7:0]               operation_setting,
	input  wire [8:0]               vout_reference_setting,
	input  wire [8:0]               margin_low_setting,
	input  wire [8:0]               margin_high_setting,
	input  wire [7:0]               vendor_config_setting,
	input  wire [7:0]               shared_rail_address,
	// address decode
	input  wire [6:0]               rx_address,
	output wire                     addr_match,
	output reg  [6:0]               own_address,
	// reference
	output reg  [8:0]               ref_present,
	output reg  [8:0]               ref_target,
	output wire                     output_on,
	output wire                     slewing
);
	// ****************************************************************
	// constants
	// ****************************************************************
	localparam       NUM_CAND   = 3;
	localparam [1:0] SRC_NORMAL = 2'b00;
	localparam [1:0] SRC_LOW    = 2'b01;
	localparam [1:0] SRC_HIGH   = 2'b10;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	reg  [2:0] strap_s1_q;
	reg  [2:0] strap_s2_q;
	reg  [2:0] flag_s1_q;
	reg  [2:0] flag_s2_q;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_s1_q <= 3'h0;
			strap_s2_q <= 3'h0;
		end else begin
			strap_s1_q <= addr_strap_pin;
			strap_s2_q <= strap_s1_q;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_s1_q <= 3'h0;
			flag_s2_q <= 3'h0;
		end else begin
			flag_s1_q <= {slew_cap_bypass, slew_cap_open, run_pin};
			flag_s2_q <= flag_s1_q;
		end
	end

	wire run_s     = flag_s2_q[0];
	wire cap_open  = flag_s2_q[1];
	wire cap_bypas = flag_s2_q[2];

	// ****************************************************************
	// strap capture
	// ****************************************************************
	reg  [1:0] por_q;
	reg        run_d1_q;
	reg        on_d1_q;
	reg        init_q;
	wire       por_done;
	wire       run_rise;
	wire       on_rise;

	assign output_on = operation_setting[`OP_ON_BIT];

	// power-on capture waits until the strap has crossed both
	// synchroniser stages, so their reset value is never taken
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			por_q <= 2'b00;
		end else begin
			por_q <= {por_q[0], 1'b1};
		end
	end

	assign por_done = por_q[0] & ~por_q[1]; // RULE_05
	assign run_rise = run_s & ~run_d1_q; // RULE_05
	assign on_rise  = output_on & ~on_d1_q; // RULE_05

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_d1_q <= 1'b0;
			on_d1_q  <= 1'b0;
			init_q   <= 1'b0;
		end else begin
			run_d1_q <= run_s;
			on_d1_q  <= output_on;
			init_q   <= por_done | run_rise | on_rise; // RULE_05
		end
	end

	// the strap is looked at only on init_q; other pin moves are ignored
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			own_address <= {`ADDR_UPPER_BITS, 3'h0};
		end else if (init_q) begin
			own_address <= {`ADDR_UPPER_BITS, strap_s2_q}; // RULE_01 RULE_02
		end
	end

	// ****************************************************************
	// address decode
	// ****************************************************************
	// entry 0 strapped, 1 global, 2 shared rail; all compared at once
	wire [6:0]          cand_addr [0:NUM_CAND-1];
	wire [NUM_CAND-1:0] cand_en;
	wire [NUM_CAND-1:0] cand_hit;
	wire                rail_en;

	assign rail_en      = ~shared_rail_address[`RAIL_DIS_BIT]; // RULE_15
	assign cand_addr[0] = own_address;
	assign cand_addr[1] = `ADDR_GLOBAL; // RULE_03
	assign cand_addr[2] = shared_rail_address[6:0]; // RULE_04
	assign cand_en      = {rail_en, 1'b1, 1'b1};

	genvar g;
	generate
		for (g = 0; g < NUM_CAND; g = g + 1) begin : g_cand
			assign cand_hit[g] = cand_en[g] & (rx_address == cand_addr[g]);
		end
	endgenerate

	assign addr_match = |cand_hit; // RULE_16

	// ****************************************************************
	// target selection
	// ****************************************************************
	// only the margin field matters; on/off leaves the reference alone
	wire [1:0] margin_sel;
	reg  [8:0] target_d;

	assign margin_sel = {operation_setting[`OP_MARGIN_HI_BIT],
		operation_setting[`OP_MARGIN_LO_BIT]};

	always @* begin
		case (margin_sel) // RULE_07 RULE_13
			SRC_LOW:    target_d = margin_low_setting;
			SRC_HIGH:   target_d = margin_high_setting;
			SRC_NORMAL: target_d = vout_reference_setting; // RULE_06
			// both margin bits set is refused: stay on the normal setting
			default:    target_d = vout_reference_setting; // RULE_08
		endcase
	end

	// ****************************************************************
	// slew stepper
	// ****************************************************************
	wire [1:0]               slew_mult;
	wire [`PERIOD_WIDTH-1:0] base_period;
	wire                     step_tick;
	wire                     step_up;
	wire                     step_down;

	assign slew_mult   = vendor_config_setting[1:0]; // RULE_14
	// an open pin falls back to the built-in rate; bypass wins over open
	assign base_period = cap_open ? DEFAULT_STEP_CYCLES // RULE_11
		: slew_cap_period;
	assign slewing     = (ref_present != ref_target);
	assign step_up     = step_tick & (ref_present < ref_target);
	assign step_down   = step_tick & (ref_present > ref_target);

	step_timer u_step_timer (
		.clk         (clk),
		.arst_n      (arst_n),
		.active      (slewing & ~cap_bypas),
		.base_period (base_period),
		.slew_mult   (slew_mult),
		.tick        (step_tick)
	); // RULE_10

	// the target follows the settings one edge late
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_target <= `REF_RESET;
		end else begin
			ref_target <= target_d; // RULE_09
		end
	end

	// bypass skips the timer and lands on the target at the next edge
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_present <= `REF_RESET;
		end else if (cap_bypas) begin
			ref_present <= ref_target; // RULE_12
		end else if (step_up) begin
			ref_present <= ref_present + 9'h001; // RULE_17 RULE_09
		end else if (step_down) begin
			ref_present <= ref_present - 9'h001; // RULE_17 RULE_09
		end
	end
endmodule // vout_reference_and_address

// ===== bench/vref_assertions.sv
`timescale 1ns/1ps
module vref_chk #(
	parameter [23:0] DEFAULT_STEP_CYCLES = 24'h00_0004
) (
	// clock and reset
	input wire       clk,
	input wire       arst_n,
	// watched
	input wire       slew_cap_bypass,
	input wire       slew_cap_open,
	input wire [7:0] operation_setting,
	input wire [8:0] vout_reference_setting,
	input wire [8:0] margin_low_setting,
	input wire [8:0] margin_high_setting,
	input wire [7:0] vendor_config_setting,
	input wire [7:0] shared_rail_address,
	input wire [6:0] rx_address,
	input wire       addr_match,
	input wire [6:0] own_address,
	input wire [8:0] ref_present,
	input wire [8:0] ref_target,
	input wire       output_on
);
// ****
// checks
// ****
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
wire [1:0] sel = operation_setting[5:4];
wire [8:0] want = sel == 2'b01 ? margin_low_setting :
	sel == 2'b10 ? margin_high_setting : vout_reference_setting;
wire rail_hit = !shared_rail_address[7] &&
	rx_address == shared_rail_address[6:0];
// bypass is synchronised inside, so its last few cycles are excluded
wire quiet = !slew_cap_bypass && !slew_cap_open;
sequence step_s; ref_present != $past(ref_present); endsequence
a_upper_fixed: assert property (own_address[6:3] == 4'h4)
	else $error("own address upper bits");
a_global_ack: assert property (rx_address == 7'h5A |-> addr_match)
	else $error("global address missed");
a_rail_ack: assert property (rail_hit |-> addr_match)
	else $error("rail address missed");
a_no_false: assert property (addr_match |-> rx_address == own_address ||
	rx_address == 7'h5A || rail_hit) else $error("false address match");
a_target_sel: assert property (1 |=> ref_target == $past(want))
	else $error("target source");
a_single_step: assert property (step_s ##0 quiet && !$past(slew_cap_bypass, 4) |->
	ref_present - $past(ref_present) == 9'h001 ||
	$past(ref_present) - ref_present == 9'h001) else $error("step size");
a_bypass_jump: assert property (slew_cap_bypass && $past(slew_cap_bypass, 4) &&
	ref_present != ref_target |=> ref_present == $past(ref_target))
	else $error("bypass jump");
a_step_gap: assert property (step_s ##0 quiet &&
	vendor_config_setting[1:0] == 2'b00 |=> $stable(ref_present)[*3])
	else $error("step period short");
a_on_copy: assert property (output_on == operation_setting[7])
	else $error("on state");
endmodule // vref_chk
bind vout_reference_and_address vref_chk #(
	.DEFAULT_STEP_CYCLES(DEFAULT_STEP_CYCLES)) vref_chk_i (
	.clk(clk), .arst_n(arst_n), .slew_cap_bypass(slew_cap_bypass),
	.slew_cap_open(slew_cap_open), .operation_setting(operation_setting),
	.vout_reference_setting(vout_reference_setting),
	.margin_low_setting(margin_low_setting),
	.margin_high_setting(margin_high_setting),
	.vendor_config_setting(vendor_config_setting),
	.shared_rail_address(shared_rail_address), .rx_address(rx_address),
	.addr_match(addr_match), .own_address(own_address),
	.ref_present(ref_present), .ref_target(ref_target),
	.output_on(output_on));

// ===== bench/host_model.sv
`timescale 1ns/1ps
module host_model (
	// clock
	input wire       clk,
	// settings as written over the bus
	output reg [7:0] operation_setting = 8'h00,
	output reg [8:0] vout_reference_setting = 9'h000,
	output reg [8:0] margin_low_setting = 9'h000,
	output reg [8:0] margin_high_setting = 9'h000,
	output reg [7:0] vendor_config_setting = 8'h00,
	output reg [7:0] shared_rail_address = 8'h80,
	output reg [6:0] rx_address = 7'h00
);
// a write commits at a rising edge, as a finished bus write would
task wr(input [7:0] o, input [8:0] v, l, h, input [7:0] c, r,
	input [6:0] a);
	begin
		@(posedge clk);
		{operation_setting, vout_reference_setting, margin_low_setting,
			margin_high_setting} <= {o, v, l, h};
		{vendor_config_setting, shared_rail_address, rx_address} <= {c, r, a};
	end
endtask
endmodule // host_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
reg         clk = 1'b0;
reg         arst_n = 1'b0;
reg  [2:0]  addr_strap_pin = 3'h5;
reg         run_pin = 1'b0;
reg         slew_cap_bypass = 1'b1;
reg         slew_cap_open = 1'b0;
wire [23:0] slew_cap_period = 24'h00_0004;
wire [7:0]  operation_setting, vendor_config_setting, shared_rail_address;
wire [8:0]  vout_reference_setting, margin_low_setting, margin_high_setting;
wire [8:0]  ref_present, ref_target;
wire [6:0]  rx_address, own_address;
wire        addr_match, output_on, slewing;
integer     n_fail = 0, checks = 0, i, k;
reg  [43:0] rows [0:4];
always #12.5 clk = ~clk;
host_model host_model_i (.clk(clk), .operation_setting(operation_setting),
	.vout_reference_setting(vout_reference_setting),
	.margin_low_setting(margin_low_setting),
	.margin_high_setting(margin_high_setting),
	.vendor_config_setting(vendor_config_setting),
	.shared_rail_address(shared_rail_address), .rx_address(rx_address));
// built-in period shorter than the capacitor one, so an open pin shows
vout_reference_and_address #(.DEFAULT_STEP_CYCLES(24'h00_0002))
	vout_reference_and_address_i (.clk(clk), .arst_n(arst_n),
	.addr_strap_pin(addr_strap_pin), .run_pin(run_pin),
	.slew_cap_open(slew_cap_open), .slew_cap_bypass(slew_cap_bypass),
	.slew_cap_period(slew_cap_period),
	.operation_setting(operation_setting),
	.vout_reference_setting(vout_reference_setting),
	.margin_low_setting(margin_low_setting),
	.margin_high_setting(margin_high_setting),
	.vendor_config_setting(vendor_config_setting),
	.shared_rail_address(shared_rail_address), .rx_address(rx_address),
	.addr_match(addr_match), .own_address(own_address),
	.ref_present(ref_present), .ref_target(ref_target),
	.output_on(output_on), .slewing(slewing));
// ****
// helpers
// ****
task chk(input string nm, input [8:0] seen, exp);
	begin
		checks = checks + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	end
endtask
task print_verdict;
	begin
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	end
endtask
task settle;
	begin
		repeat (3) @(posedge clk);
		for (k = 0; k < 200 && ref_present !== ref_target; k = k + 1)
			@(posedge clk);
		if (k == 200) begin
			n_fail = n_fail + 1;
			print_verdict;
		end
	end
endtask
task adr(input [7:0] r, input [6:0] a, input e);
	begin
		host_model_i.wr(8'h00, 9'h000, 9'h000, 9'h000, 8'h00, r, a);
		@(posedge clk);
		chk("addr_match", addr_match, e);
	end
endtask
// ****
// sequence
// ****
initial begin
	rows[0] = {8'h80, 9'h1ff, 9'h010, 9'h020, 9'h1ff};
	rows[1] = {8'h98, 9'h100, 9'h003, 9'h1f0, 9'h003};
	rows[2] = {8'hA8, 9'h100, 9'h003, 9'h1f0, 9'h1f0};
	rows[3] = {8'hB8, 9'h0aa, 9'h003, 9'h1f0, 9'h0aa};
	rows[4] = {8'h00, 9'h000, 9'h003, 9'h1f0, 9'h000};
	repeat (10) @(posedge clk);
	arst_n <= 1'b1;
	for (i = 0; i < 5; i = i + 1) begin
		host_model_i.wr(rows[i][43:36], rows[i][35:27], rows[i][26:18],
			rows[i][17:9], 8'h00, 8'h80, 7'h00);
		settle;
		chk("ref_target", ref_target, rows[i][8:0]);
		chk("ref_present", ref_present, rows[i][8:0]);
		chk("output_on", output_on, rows[i][43]);
	end
	$display("test rows done");
	chk("own_address", own_address, 9'h025);
	adr(8'h80, 7'h25, 1'b1);
	adr(8'h80, 7'h5A, 1'b1);
	adr(8'h33, 7'h33, 1'b1);
	adr(8'hB3, 7'h33, 1'b0);
	adr(8'h80, 7'h26, 1'b0);
	$display("test address done");
	addr_strap_pin <= 3'h2;
	repeat (10) @(posedge clk);
	chk("own_address", own_address, 9'h025);
	run_pin <= 1'b1;
	repeat (10) @(posedge clk);
	chk("own_address", own_address, 9'h022);
	addr_strap_pin <= 3'h7;
	host_model_i.wr(8'h80, 9'h000, 9'h000, 9'h000, 8'h00, 8'h80, 7'h00);
	repeat (10) @(posedge clk);
	chk("own_address", own_address, 9'h027);
	$display("test strap done");
	slew_cap_bypass <= 1'b0;
	repeat (6) @(posedge clk);
	host_model_i.wr(8'h80, 9'h003, 9'h000, 9'h000, 8'h00, 8'h80, 7'h00);
	repeat (6) @(posedge clk);
	chk("slewing", slewing, 1'b1);
	settle;
	chk("ref_present", ref_present, 9'h003);
	// slow multiplier stretches each step eightfold
	host_model_i.wr(8'h80, 9'h000, 9'h000, 9'h000, 8'h01, 8'h80, 7'h00);
	repeat (20) @(posedge clk);
	chk("slewing", slewing, 1'b1);
	settle;
	chk("ref_present", ref_present, 9'h000);
	// fast multiplier halves the step: three codes inside 11 cycles
	host_model_i.wr(8'h80, 9'h003, 9'h000, 9'h000, 8'h02, 8'h80, 7'h00);
	repeat (11) @(posedge clk);
	chk("slewing", slewing, 1'b0);
	chk("ref_present", ref_present, 9'h003);
	// illegal multiplier code runs at the nominal rate
	host_model_i.wr(8'h80, 9'h000, 9'h000, 9'h000, 8'h03, 8'h80, 7'h00);
	repeat (11) @(posedge clk);
	chk("slewing", slewing, 1'b1);
	settle;
	chk("ref_present", ref_present, 9'h000);
	// open capacitor pin takes the built-in period of two cycles
	slew_cap_open <= 1'b1;
	host_model_i.wr(8'h80, 9'h003, 9'h000, 9'h000, 8'h00, 8'h80, 7'h00);
	repeat (11) @(posedge clk);
	chk("slewing", slewing, 1'b0);
	chk("ref_present", ref_present, 9'h003);
	host_model_i.wr(8'h00, 9'h000, 9'h000, 9'h000, 8'h00, 8'h80, 7'h00);
	settle;
	$display("test slew done");
	// mid-run reset: strap moved while held, taken again after release
	addr_strap_pin <= 3'h1;
	arst_n <= 1'b0;
	repeat (2) @(posedge clk);
	chk("own_address", own_address, 9'h020);
	chk("ref_present", ref_present, 9'h000);
	arst_n <= 1'b1;
	repeat (5) @(posedge clk);
	chk("own_address", own_address, 9'h021);
	$display("test reset done");
	print_verdict;
end
endmodule // tb
